// File: verilog/rrm_regs.vh
// register map constants for the reader register bank
`ifndef RRM_REGS_VH
`define RRM_REGS_VH

// address and data widths
`define RRM_AW 6
`define RRM_DW 8
`define RRM_NREG 64
`define RRM_ZERO 8'h00

// io and operation control, power-up reset only
`define RRM_IO_CONFIG_ONE 6'h00
`define RRM_IO_CONFIG_TWO 6'h01
`define RRM_OPERATION_CONTROL 6'h02
// mode, receiver and timer configuration
`define RRM_PROTOCOL_MODE_SELECT 6'h03
`define RRM_BIT_RATE_SELECT 6'h04
`define RRM_TYPE_A_SETTINGS 6'h05
`define RRM_TYPE_B_SETTINGS_ONE 6'h06
`define RRM_TYPE_B_SETTINGS_TWO 6'h07
`define RRM_RAW_STREAM_SETUP 6'h08
`define RRM_AUXILIARY_SETUP 6'h09
`define RRM_RX_CONFIG_ONE 6'h0a
`define RRM_RX_CONFIG_TWO 6'h0b
`define RRM_RX_CONFIG_THREE 6'h0c
`define RRM_RX_CONFIG_FOUR 6'h0d
`define RRM_RX_BLANKING_TIME 6'h0e
`define RRM_REPLY_TIMEOUT_HIGH 6'h0f
`define RRM_REPLY_TIMEOUT_LOW 6'h10
`define RRM_TIMERS_CONTROL 6'h11
`define RRM_GENERAL_TIMER_HIGH 6'h12
`define RRM_GENERAL_TIMER_LOW 6'h13
// interrupt masks and status
`define RRM_IRQ_MASK_MAIN 6'h14
`define RRM_IRQ_MASK_TIMER_PEER 6'h15
`define RRM_IRQ_MASK_ERROR_WAKE 6'h16
`define RRM_IRQ_STATUS_MAIN 6'h17
`define RRM_IRQ_STATUS_TIMER_PEER 6'h18
`define RRM_IRQ_STATUS_ERROR_WAKE 6'h19
// buffer and collision
`define RRM_BUFFER_STATUS_ONE 6'h1a
`define RRM_BUFFER_STATUS_TWO 6'h1b
`define RRM_COLLISION_REPORT 6'h1c
`define RRM_TX_BYTE_COUNT_HIGH 6'h1d
`define RRM_TX_BYTE_COUNT_LOW 6'h1e
`define RRM_PEER_RATE_DETECT 6'h1f
`define RRM_ADC_RESULT 6'h20
`define RRM_TUNING_CONTROL 6'h21
`define RRM_TUNING_TARGET 6'h22
`define RRM_TUNING_RESULT 6'h23
`define RRM_MOD_DEPTH_RESULT 6'h25
`define RRM_UNMAPPED_A 6'h28
`define RRM_REGULATOR_TIMER_REPORT 6'h2b
`define RRM_SIGNAL_STRENGTH_REPORT 6'h2c
`define RRM_GAIN_STATE_REPORT 6'h2d
`define RRM_CAP_SENSE_RESULT 6'h2f
`define RRM_AUXILIARY_REPORT 6'h30
// writable analogue setup
`define RRM_MOD_DEPTH_CONTROL 6'h24
`define RRM_DRIVER_MODULATED_LEVEL 6'h26
`define RRM_DRIVER_NORMAL_LEVEL 6'h27
`define RRM_FIELD_DETECT_THRESHOLD 6'h29
`define RRM_REGULATOR_CONTROL 6'h2a
`define RRM_CAP_SENSE_CONTROL 6'h2e
// wake-up configuration, references and reports
`define RRM_WAKE_TIMER_CONTROL 6'h31
`define RRM_WAKE_AMP_CONFIG 6'h32
`define RRM_WAKE_AMP_REFERENCE 6'h33
`define RRM_WAKE_AMP_AVERAGE 6'h34
`define RRM_WAKE_AMP_RESULT 6'h35
`define RRM_WAKE_PHASE_CONFIG 6'h36
`define RRM_WAKE_PHASE_REFERENCE 6'h37
`define RRM_WAKE_PHASE_AVERAGE 6'h38
`define RRM_WAKE_PHASE_RESULT 6'h39
`define RRM_WAKE_CAP_CONFIG 6'h3a
`define RRM_WAKE_CAP_REFERENCE 6'h3b
`define RRM_WAKE_CAP_AVERAGE 6'h3c
`define RRM_WAKE_CAP_RESULT 6'h3d
`define RRM_UNMAPPED_B 6'h3e
`define RRM_IDENTITY 6'h3f

// default value loaded into every writable register (plain, not documented)
`define RRM_DEFAULT 8'h00
// identity register value, arbitrary
`define RRM_IDENTITY_VALUE 8'h5a

`endif

// File: verilog/rrm_cell.v
// one eight-bit configuration register cell with two reset sources
`timescale 1ns/100ps
`default_nettype none
`include "rrm_regs.vh"

module rrm_cell
#(
    parameter [`RRM_DW-1:0] DEFAULT_VALUE = `RRM_DEFAULT // value loaded by either reset
)
(
    input wire mclk,                  // system clock
    input wire rst,                   // power-up reset, async, high
    input wire soft_clr,              // restore-defaults pulse
    input wire keep_on_soft,          // cell ignores restore-defaults
    input wire wr_en,                 // write strobe for this cell
    input wire [`RRM_DW-1:0] wr_data, // data to store
    output reg [`RRM_DW-1:0] q_r      // stored value
);

    // ========================================================
    // storage
    // ========================================================
    // restore-defaults wins over a write in the same cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q_r <= DEFAULT_VALUE;
        end
        else if (soft_clr && !keep_on_soft)
        begin
            q_r <= DEFAULT_VALUE;
        end
        else if (wr_en)
        begin
            q_r <= wr_data;
        end
    end

endmodule // rrm_cell

`default_nettype wire

// File: verilog/rrm_bank.v
// register bank of the reader front end: decode, storage and read mux
// Function
// - six-bit address, locations zero to sixty-three
// - configuration registers read back last write
// - display registers read-only, writes ignored
// - power-up and restore-defaults load defaults
// - first three registers reset at power-up only
// - status 17h-19h read-only, masks 14h-16h writable
// - buffer status 1Ah, 1Bh read-only
// - transmit byte count writable at 1Dh, 1Eh
// - conversion result read-only at 20h
// - tuning 21h, 22h writable, 23h read-only
`timescale 1ns/100ps
`default_nettype none
`include "rrm_regs.vh"

module rrm_bank
(
    input wire mclk,                       // system clock, 250 MHz
    input wire rst,                        // power-up reset, async, high
    input wire restore_defaults,           // restore-defaults command pulse
    input wire wr_en,                      // host write strobe
    input wire rd_en,                      // host read strobe
    input wire [`RRM_AW-1:0] addr,         // register address
    input wire [`RRM_DW-1:0] wr_data,      // host write data
    input wire [`RRM_DW-1:0] irq_main_in,  // live main interrupt status
    input wire [`RRM_DW-1:0] irq_tp_in,    // live timer and peer status
    input wire [`RRM_DW-1:0] irq_ew_in,    // live error and wake status
    input wire [`RRM_DW-1:0] buf_one_in,   // buffer status one
    input wire [`RRM_DW-1:0] buf_two_in,   // buffer status two
    input wire [`RRM_DW-1:0] coll_in,      // collision report
    input wire [`RRM_DW-1:0] rate_in,      // peer rate detect
    input wire [`RRM_DW-1:0] adc_in,       // conversion result
    input wire [`RRM_DW-1:0] tune_in,      // tuning result
    input wire [`RRM_DW-1:0] mod_in,       // modulation depth result
    input wire [`RRM_DW-1:0] regt_in,      // regulator and timer report
    input wire [`RRM_DW-1:0] rssi_in,      // signal strength report
    input wire [`RRM_DW-1:0] gain_in,      // gain state report
    input wire [`RRM_DW-1:0] cap_in,       // capacitive sensor result
    input wire [`RRM_DW-1:0] aux_in,       // auxiliary report
    input wire [`RRM_DW-1:0] wake_disp_in, // wake-up display bytes, shared
    output reg [`RRM_DW-1:0] rd_data_r,    // read data, held until next read
    output reg rd_valid_r,                 // read data valid pulse
    output reg [`RRM_DW-1:0] io_config_one_r,     // copy of 00h
    output reg [`RRM_DW-1:0] io_config_two_r,     // copy of 01h
    output reg [`RRM_DW-1:0] operation_control_r, // copy of 02h
    output reg [`RRM_DW-1:0] tx_byte_count_high_r, // copy of 1Dh
    output reg [`RRM_DW-1:0] tx_byte_count_low_r   // copy of 1Eh
);

    // ========================================================
    // address map overview
    // ========================================================
    // 00h-02h hardware configuration, cleared at power-up only
    // 03h-13h mode, receiver and timer configuration
    // 14h-16h interrupt masks, writable
    // 17h-19h interrupt status, live from the core
    // 1Ah-1Ch buffer and collision reports
    // 1Dh-1Eh transmit byte count, writable
    // 1Fh-20h peer rate and conversion reports
    // 21h-27h tuning, modulation depth and driver levels
    // 28h hole, reads zero
    // 29h-2Fh field threshold, regulator, receiver and sensor
    // 30h auxiliary report
    // 31h-3Dh wake-up configuration and reports
    // 3Eh hole, reads zero
    // 3Fh identity, constant
    // the core owns every display value; this bank only samples
    // them on a read, so a display never needs a reset of its own

    // ========================================================
    // write decode
    // ========================================================
    reg rw_sel; // current address holds a configuration register

    // one line per writable address keeps the map easy to audit;
    // anything missing here is a display, a hole or the identity,
    // so a host write to it is dropped without a trace
    always @*
    begin
        case (addr)
            `RRM_IO_CONFIG_ONE: rw_sel = 1'b1;
            `RRM_IO_CONFIG_TWO: rw_sel = 1'b1;
            `RRM_OPERATION_CONTROL: rw_sel = 1'b1;
            `RRM_PROTOCOL_MODE_SELECT: rw_sel = 1'b1;
            `RRM_BIT_RATE_SELECT: rw_sel = 1'b1;
            `RRM_TYPE_A_SETTINGS: rw_sel = 1'b1;
            `RRM_TYPE_B_SETTINGS_ONE: rw_sel = 1'b1;
            `RRM_TYPE_B_SETTINGS_TWO: rw_sel = 1'b1;
            `RRM_RAW_STREAM_SETUP: rw_sel = 1'b1;
            `RRM_AUXILIARY_SETUP: rw_sel = 1'b1;
            `RRM_RX_CONFIG_ONE: rw_sel = 1'b1;
            `RRM_RX_CONFIG_TWO: rw_sel = 1'b1;
            `RRM_RX_CONFIG_THREE: rw_sel = 1'b1;
            `RRM_RX_CONFIG_FOUR: rw_sel = 1'b1;
            `RRM_RX_BLANKING_TIME: rw_sel = 1'b1;
            `RRM_REPLY_TIMEOUT_HIGH: rw_sel = 1'b1;
            `RRM_REPLY_TIMEOUT_LOW: rw_sel = 1'b1;
            `RRM_TIMERS_CONTROL: rw_sel = 1'b1;
            `RRM_GENERAL_TIMER_HIGH: rw_sel = 1'b1;
            `RRM_GENERAL_TIMER_LOW: rw_sel = 1'b1;
            `RRM_IRQ_MASK_MAIN: rw_sel = 1'b1;
            `RRM_IRQ_MASK_TIMER_PEER: rw_sel = 1'b1;
            `RRM_IRQ_MASK_ERROR_WAKE: rw_sel = 1'b1;
            `RRM_TX_BYTE_COUNT_HIGH: rw_sel = 1'b1;
            `RRM_TX_BYTE_COUNT_LOW: rw_sel = 1'b1;
            `RRM_TUNING_CONTROL: rw_sel = 1'b1;
            `RRM_TUNING_TARGET: rw_sel = 1'b1;
            `RRM_MOD_DEPTH_CONTROL: rw_sel = 1'b1;
            `RRM_DRIVER_MODULATED_LEVEL: rw_sel = 1'b1;
            `RRM_DRIVER_NORMAL_LEVEL: rw_sel = 1'b1;
            `RRM_FIELD_DETECT_THRESHOLD: rw_sel = 1'b1;
            `RRM_REGULATOR_CONTROL: rw_sel = 1'b1;
            `RRM_CAP_SENSE_CONTROL: rw_sel = 1'b1;
            `RRM_WAKE_TIMER_CONTROL: rw_sel = 1'b1;
            `RRM_WAKE_AMP_CONFIG: rw_sel = 1'b1;
            `RRM_WAKE_AMP_REFERENCE: rw_sel = 1'b1;
            `RRM_WAKE_PHASE_CONFIG: rw_sel = 1'b1;
            `RRM_WAKE_PHASE_REFERENCE: rw_sel = 1'b1;
            `RRM_WAKE_CAP_CONFIG: rw_sel = 1'b1;
            `RRM_WAKE_CAP_REFERENCE: rw_sel = 1'b1;
            default: rw_sel = 1'b0;
        endcase
    end

    // ========================================================
    // storage
    // ========================================================
    // every address gets a cell; holes and display slots never write
    // and are not read, so their cells are trimmed away by synthesis
    wire [`RRM_DW-1:0] cell_q [0:`RRM_NREG-1]; // stored values
    genvar g;
    // the first three cells ignore restore-defaults; the rest clear on it
    generate
        for (g = 0; g < `RRM_NREG; g = g + 1)
        begin : g_cell
            rrm_cell #
            (
                .DEFAULT_VALUE(`RRM_DEFAULT)
            )
            u_cell
            (
                .mclk(mclk),
                .rst(rst),
                .soft_clr(restore_defaults),
                .keep_on_soft((g <= `RRM_OPERATION_CONTROL) ? 1'b1 : 1'b0),
                .wr_en(wr_en && rw_sel && (addr == g)),
                .wr_data(wr_data),
                .q_r(cell_q[g])
            );
        end
    endgenerate

    // ========================================================
    // display decode
    // ========================================================
    reg [`RRM_DW-1:0] disp_val; // live value at a display address
    reg disp_hit; // address is a display or the identity

    // displays pass straight through from the core; holes fall to
    // a branch that leaves the hit flag clear
    always @*
    begin
        disp_val = `RRM_ZERO;
        disp_hit = 1'b0;
        case (addr)
            `RRM_IRQ_STATUS_MAIN:
            begin
                disp_val = irq_main_in;
                disp_hit = 1'b1;
            end
            `RRM_IRQ_STATUS_TIMER_PEER:
            begin
                disp_val = irq_tp_in;
                disp_hit = 1'b1;
            end
            `RRM_IRQ_STATUS_ERROR_WAKE:
            begin
                disp_val = irq_ew_in;
                disp_hit = 1'b1;
            end
            `RRM_BUFFER_STATUS_ONE:
            begin
                disp_val = buf_one_in;
                disp_hit = 1'b1;
            end
            `RRM_BUFFER_STATUS_TWO:
            begin
                disp_val = buf_two_in;
                disp_hit = 1'b1;
            end
            `RRM_COLLISION_REPORT:
            begin
                disp_val = coll_in;
                disp_hit = 1'b1;
            end
            `RRM_PEER_RATE_DETECT:
            begin
                disp_val = rate_in;
                disp_hit = 1'b1;
            end
            `RRM_ADC_RESULT:
            begin
                disp_val = adc_in;
                disp_hit = 1'b1;
            end
            `RRM_TUNING_RESULT:
            begin
                disp_val = tune_in;
                disp_hit = 1'b1;
            end
            `RRM_MOD_DEPTH_RESULT:
            begin
                disp_val = mod_in;
                disp_hit = 1'b1;
            end
            `RRM_REGULATOR_TIMER_REPORT:
            begin
                disp_val = regt_in;
                disp_hit = 1'b1;
            end
            `RRM_SIGNAL_STRENGTH_REPORT:
            begin
                disp_val = rssi_in;
                disp_hit = 1'b1;
            end
            `RRM_GAIN_STATE_REPORT:
            begin
                disp_val = gain_in;
                disp_hit = 1'b1;
            end
            `RRM_CAP_SENSE_RESULT:
            begin
                disp_val = cap_in;
                disp_hit = 1'b1;
            end
            `RRM_AUXILIARY_REPORT:
            begin
                disp_val = aux_in;
                disp_hit = 1'b1;
            end
            // the six wake-up reports share one input; the core muxes it
            `RRM_WAKE_AMP_AVERAGE:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_WAKE_AMP_RESULT:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_WAKE_PHASE_AVERAGE:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_WAKE_PHASE_RESULT:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_WAKE_CAP_AVERAGE:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_WAKE_CAP_RESULT:
            begin
                disp_val = wake_disp_in;
                disp_hit = 1'b1;
            end
            `RRM_IDENTITY:
            begin
                disp_val = `RRM_IDENTITY_VALUE;
                disp_hit = 1'b1;
            end
            `RRM_UNMAPPED_A, `RRM_UNMAPPED_B:
            begin
                disp_val = `RRM_ZERO;
                disp_hit = 1'b0;
            end
            default:
            begin
                disp_val = `RRM_ZERO;
                disp_hit = 1'b0;
            end
        endcase
    end

    // ========================================================
    // read multiplexer
    // ========================================================
    reg [`RRM_DW-1:0] rd_nxt; // selected read value

    // storage first, then displays, and zero for every hole
    always @*
    begin
        if (rw_sel)
        begin
            rd_nxt = cell_q[addr];
        end
        else if (disp_hit)
        begin
            rd_nxt = disp_val;
        end
        else
        begin
            rd_nxt = `RRM_ZERO;
        end
    end

    // ========================================================
    // read register and exported copies
    // ========================================================
    // outputs come from flops; copies lag storage by one cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_r <= `RRM_ZERO;
            rd_valid_r <= 1'b0;
            io_config_one_r <= `RRM_DEFAULT;
            io_config_two_r <= `RRM_DEFAULT;
            operation_control_r <= `RRM_DEFAULT;
            tx_byte_count_high_r <= `RRM_DEFAULT;
            tx_byte_count_low_r <= `RRM_DEFAULT;
        end
        else
        begin
            rd_valid_r <= rd_en;
            if (rd_en)
                rd_data_r <= rd_nxt;
            io_config_one_r <= cell_q[`RRM_IO_CONFIG_ONE];
            io_config_two_r <= cell_q[`RRM_IO_CONFIG_TWO];
            operation_control_r <= cell_q[`RRM_OPERATION_CONTROL];
            tx_byte_count_high_r <= cell_q[`RRM_TX_BYTE_COUNT_HIGH];
            tx_byte_count_low_r <= cell_q[`RRM_TX_BYTE_COUNT_LOW];
        end
    end

endmodule // rrm_bank

`default_nettype wire

// File: tb/rrm_bank_assertions.sv
// checker for the reader register bank ports
`timescale 1ns/100ps
`default_nettype none
module rrm_bank_assertions
(
    input wire logic mclk, // system clock
    input wire logic rst, // power-up reset
    input wire logic restore_defaults, // restore pulse
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic rd_valid_r, // read valid
    input wire logic [5:0] addr, // register address
    input wire logic [7:0] wr_data, // write data
    input wire logic [7:0] irq_main_in, // live main status
    input wire logic [7:0] adc_in, // live conversion result
    input wire logic [7:0] rd_data_r, // read data
    input wire logic [7:0] operation_control_r, // copy of 02h
    input wire logic [7:0] tx_byte_count_high_r, // copy of 1Dh
    input wire logic [7:0] tx_byte_count_low_r // copy of 1Eh
);
    // ==========================================================
    // read handshake, decode and reset-source relations
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_rd_ack; rd_en |=> rd_valid_r; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_no_ack; !rd_en |=> !rd_valid_r; endproperty
    a_no_ack: assert property (p_no_ack) else $error("valid without read");
    property p_hold; !rd_en |=> $stable(rd_data_r); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unm; rd_en && (addr == 6'h28 || addr == 6'h3e) |=> rd_data_r == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_ident; rd_en && addr == 6'h3f |=> rd_data_r == 8'h5a; endproperty
    a_ident: assert property (p_ident) else $error("identity wrong");
    property p_stat; rd_en && addr == 6'h17 |=> rd_data_r == $past(irq_main_in); endproperty
    a_stat: assert property (p_stat) else $error("status not live");
    property p_adc; rd_en && addr == 6'h20 |=> rd_data_r == $past(adc_in); endproperty
    a_adc: assert property (p_adc) else $error("conversion not live");
    // the copy output lags storage by one cycle, hence the two-cycle offsets
    property p_keep; restore_defaults && !wr_en |-> ##2 $stable(operation_control_r); endproperty
    a_keep: assert property (p_keep) else $error("control lost on restore");
    // a write to the low count right after restore legally refills it
    property p_clr;
        restore_defaults ##1 !(wr_en && addr == 6'h1e) |=> tx_byte_count_low_r == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("count kept on restore");
    property p_cnt;
        wr_en && !restore_defaults && addr == 6'h1d
            ##1 !restore_defaults && !(wr_en && addr == 6'h1d)
            |=> tx_byte_count_high_r == $past(wr_data, 2);
    endproperty
    a_cnt: assert property (p_cnt) else $error("count write lost");
endmodule // rrm_bank_assertions
bind rrm_bank rrm_bank_assertions rrm_bank_assertions_inst (.*);
`default_nettype wire

// File: tb/rrm_host.sv
// host model: register reads, writes and restore-defaults pulses
`timescale 1ns/100ps
`default_nettype none
module rrm_host
(
    input wire logic mclk, // system clock
    input wire logic [7:0] rd_data_r, // read data
    input wire logic rd_valid_r, // read data valid
    output var logic restore_defaults, // restore pulse
    output var logic wr_en, // write strobe
    output var logic rd_en, // read strobe
    output var logic [5:0] addr, // address
    output var logic [7:0] wr_data // write data
);
    // ==========================================================
    // bus tasks: one-cycle strobes, released lines show inverted values
    initial {restore_defaults, wr_en, rd_en, addr, wr_data} = '0;
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wr_en, addr, wr_data} <= {1'b1, a, d};
        @(posedge mclk);
        {wr_en, addr, wr_data} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        {rd_en, addr} <= {1'b1, a};
        @(posedge mclk);
        {rd_en, addr} <= {1'b0, ~a};
        @(negedge mclk);
        // a missing valid pulse yields unknown, which never matches
        d = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
    endtask
    task automatic rs();
        @(posedge mclk);
        restore_defaults <= 1'b1;
        @(posedge mclk);
        restore_defaults <= 1'b0;
    endtask
endmodule // rrm_host
`default_nettype wire

// File: tb/rrm_bank_test.sv
// self-checking bench for the reader register bank
`timescale 1ns/100ps
`default_nettype none
module rrm_bank_test;
    // ==========================================================
    // clock, display inputs and reference contents
    logic mclk = 1'b0; // 250 MHz
    logic rst = 1'b1; // power-up reset
    logic [7:0] dv [16] = '{default: 8'h00}; // live display values
    logic [7:0] mem [64] = '{default: 8'h00}; // expected stored bytes
    logic [7:0] rdat, wdat;
    logic rval, rsd, wen, ren;
    logic [5:0] adr;
    logic [7:0] cp [5]; // copies of 00h, 01h, 02h, 1Dh, 1Eh
    logic [5:0] cl [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h1d, 6'h1e, 6'h28, 6'h3e, 6'h17, 6'h3f};
    logic [5:0] ra [21] = '{6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1f, 6'h20, 6'h23,
        6'h25, 6'h2b, 6'h2c, 6'h2d, 6'h2f, 6'h30, 6'h34, 6'h35, 6'h38, 6'h39, 6'h3c, 6'h3d};
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #2 mclk = ~mclk;
    rrm_bank rrm_bank_inst (.mclk(mclk), .rst(rst), .restore_defaults(rsd), .wr_en(wen),
        .rd_en(ren), .addr(adr), .wr_data(wdat), .irq_main_in(dv[0]), .irq_tp_in(dv[1]),
        .irq_ew_in(dv[2]), .buf_one_in(dv[3]), .buf_two_in(dv[4]), .coll_in(dv[5]),
        .rate_in(dv[6]), .adc_in(dv[7]), .tune_in(dv[8]), .mod_in(dv[9]), .regt_in(dv[10]),
        .rssi_in(dv[11]), .gain_in(dv[12]), .cap_in(dv[13]), .aux_in(dv[14]),
        .wake_disp_in(dv[15]), .rd_data_r(rdat), .rd_valid_r(rval), .io_config_one_r(cp[0]),
        .io_config_two_r(cp[1]), .operation_control_r(cp[2]), .tx_byte_count_high_r(cp[3]),
        .tx_byte_count_low_r(cp[4]));
    rrm_host rrm_host_inst (.mclk(mclk), .rd_data_r(rdat), .rd_valid_r(rval),
        .restore_defaults(rsd), .wr_en(wen), .rd_en(ren), .addr(adr), .wr_data(wdat));
    // ==========================================================
    // expectations: writable bytes, live displays, zero holes, identity
    function automatic logic wrable(input logic [5:0] a);
        return a <= 6'h16 || a inside {6'h1d, 6'h1e, 6'h21, 6'h22, 6'h24, 6'h26, 6'h27, 6'h29,
            6'h2a, 6'h2e, 6'h31, 6'h32, 6'h33, 6'h36, 6'h37, 6'h3a, 6'h3b};
    endfunction
    function automatic logic [7:0] expv(input logic [5:0] a);
        expv = (a == 6'h3f) ? 8'h5a : 8'h00;
        if (wrable(a)) expv = mem[a];
        for (int i = 0; i < 21; i++) if (ra[i] == a) expv = dv[i < 15 ? i : 15];
    endfunction
    task automatic chk(input logic [5:0] a, input logic [7:0] g);
        tests_run++;
        if (g !== expv(a))
        begin
            num_errors++;
            $display("[FAIL] reg %h expected %h seen %h", a, expv(a), g);
        end
    endtask
    // exported copies follow storage one cycle late, long settled here
    task automatic chkcp();
        logic [5:0] ca [5] = '{6'h00, 6'h01, 6'h02, 6'h1d, 6'h1e};
        for (int i = 0; i < 5; i++)
        begin
            tests_run++;
            if (cp[i] !== mem[ca[i]])
            begin
                num_errors++;
                $display("[FAIL] copy %h expected %h seen %h", ca[i], mem[ca[i]], cp[i]);
            end
        end
    endtask
    // restore leaves the three hardware registers alone
    task automatic restore();
        rrm_host_inst.rs();
        for (int k = 3; k < 64; k++) mem[k] = 8'h00;
    endtask
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            num_errors++;
            finish_test();
        end
    end
    // ==========================================================
    // reset sweep, hand-picked corners, then random traffic
    initial
    begin
        logic [7:0] d;
        logic [5:0] a;
        logic [5:0] b;
        void'($urandom(32'h6799));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 64; k++)
        begin
            rrm_host_inst.rd(6'(k), d);
            chk(6'(k), d);
        end
        foreach (cl[k])
        begin
            rrm_host_inst.wr(cl[k], {2'b10, cl[k]});
            if (wrable(cl[k])) mem[cl[k]] = {2'b10, cl[k]};
        end
        restore();
        foreach (cl[k])
        begin
            rrm_host_inst.rd(cl[k], d);
            chk(cl[k], d);
        end
        chkcp();
        repeat (400)
        begin
            @(posedge mclk);
            foreach (dv[j]) dv[j] <= 8'($urandom);
            a = 6'($urandom);
            d = 8'($urandom);
            rrm_host_inst.wr(a, d);
            if (wrable(a)) mem[a] = d;
            if ($urandom_range(15) == 0) restore();
            b = $urandom_range(1) ? a : 6'($urandom);
            rrm_host_inst.rd(b, d);
            chk(b, d);
            chkcp();
        end
        finish_test();
    end
endmodule // rrm_bank_test
`default_nettype wire
